/* verilog/trace_id_regs.sv */
// identification and capability register bank of the trace-port sink
//
// Contract
// R1: three two-bit permission fields, codes 0,1,2,3
// R2: architecture word reads all zero
// R3: capability word is read-only 0x00000020
// R4: clock-relationship bit reads one, asynchronous
// R5: input multiplexing field reads zero
// R6: buffer depth field reads zero, hidden
// R7: both serial output support bits read zero
// R8: capture-control support bit, value resolved
// R9: clock-plus-data support bit reads zero
// R10: device class reads 0x00000011
// R11: identification size field reads zero
// R12: id bits 31..8 zero, ids 5-7 zero
// R13: 12-bit part number across ids 0,1
// R14: designer code across ids 4,1,2
// R15: writes to read-only words ignored
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module trace_id_regs #(
   parameter logic [2:0]  PERM_IMPL = 3'h7,   // fields wired to a source
   parameter logic [11:0] PART_NUM  = 12'h123, // arbitrary value
   parameter logic [6:0]  DESIGNER  = 7'h25,   // arbitrary value
   parameter logic [3:0]  CONTIN    = 4'h3,    // arbitrary value
   parameter logic [3:0]  REVISION  = 4'h2     // arbitrary value
) (
   input  wire logic        core_clk_in,     // block clock, 10 MHz
   input  wire logic        nrst_in,         // async reset, active low
   input  wire logic [11:0] addr_in,         // byte address
   input  wire logic [31:0] wdata_in,        // write data
   input  wire logic        wr_in,           // write strobe
   input  wire logic        rd_in,           // read strobe
   input  wire logic [2:0]  perm_enable_in,  // permission enables
   output logic [31:0]      rdata_out        // read data, next cycle
);

   ////////////////////////////////////////////////////////////////////////
   // state

   // all state of this module
   typedef struct packed {
      logic [5:0] perm;  // permission snapshot
      logic       hold;  // freeze the snapshot
   } regs_t;

   regs_t       st_q;       // registered state
   regs_t       st_d;       // next state
   logic [5:0]  perm_live;  // permission codes from the enables
   logic [31:0] cap_word;   // capability word from its fields
   logic [31:0] live_word;  // word handed to the read port
   logic        live_sel;   // address is not a table word

   ////////////////////////////////////////////////////////////////////////
   // permission codes

   // one two-bit field per enable; an unwired field reports absent,
   // so software never sees the reserved code
   for (genvar i = 0; i < trace_id_pkg::PERM_FIELDS; i++) begin : g_perm
      always_comb begin
         if (!PERM_IMPL[i]) begin
            perm_live[2*i +: 2] = trace_id_pkg::PERM_ABSENT; // R1
         end else if (perm_enable_in[i]) begin
            perm_live[2*i +: 2] = trace_id_pkg::PERM_ENABLED; // R1
         end else begin
            perm_live[2*i +: 2] = trace_id_pkg::PERM_DISABLED; // R1
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // capability word

   // built from its fields so each one is visible on its own
   always_comb begin
      cap_word = trace_id_pkg::ZERO_WORD;
      cap_word[trace_id_pkg::MUX_KIND_MSB:trace_id_pkg::MUX_KIND_LSB] =
         trace_id_pkg::MUX_KIND_VAL; // R5
      cap_word[trace_id_pkg::CLOCK_REL_BIT] =
         trace_id_pkg::CLOCK_REL_VAL; // R4
      cap_word[trace_id_pkg::DEPTH_MSB:trace_id_pkg::DEPTH_LSB] =
         trace_id_pkg::DEPTH_VAL; // R6
      // the support claim is overruled by the printed value
      cap_word[trace_id_pkg::CLK_DATA_BIT] =
         trace_id_pkg::CLK_DATA_VAL; // R9
      cap_word[trace_id_pkg::SER_MAN_BIT] =
         trace_id_pkg::SER_MAN_VAL; // R7
      cap_word[trace_id_pkg::SER_NRZ_BIT] =
         trace_id_pkg::SER_NRZ_VAL; // R7
      // kept at zero so the whole word matches its reset value
      cap_word[trace_id_pkg::CAPTURE_CTRL_BIT] =
         trace_id_pkg::CAPTURE_VAL; // R8
   end

   ////////////////////////////////////////////////////////////////////////
   // read decode for words not held in the table

   // table words go to the read port; everything else is chosen here
   always_comb begin
      live_sel  = 1'b1;
      live_word = trace_id_pkg::ZERO_WORD;
      unique case (addr_in)
         // hold control reads back
         trace_id_pkg::PERM_HOLD_OFF: begin
            live_word[0] = st_q.hold;
         end
         // permission snapshot in the low six bits
         trace_id_pkg::PERM_STATUS_OFF: begin
            live_word[5:0] = st_q.perm; // R1
         end
         // no architecture identification given
         trace_id_pkg::ARCH_ID_OFF: begin
            live_word = trace_id_pkg::ARCH_ID_VAL; // R2
         end
         // capability word
         trace_id_pkg::DEV_CAP_OFF: begin
            live_word = cap_word; // R3
         end
         // trace sink, trace port
         trace_id_pkg::DEV_CLASS_OFF: begin
            live_word = trace_id_pkg::DEV_CLASS_VAL; // R10
         end
         // identification words come from the table
         trace_id_pkg::PID4_OFF, trace_id_pkg::PID5_OFF,
         trace_id_pkg::PID6_OFF, trace_id_pkg::PID7_OFF,
         trace_id_pkg::PID0_OFF, trace_id_pkg::PID1_OFF,
         trace_id_pkg::PID2_OFF: begin
            live_sel = 1'b0; // R12
         end
         // unmapped: reads zero
         default: begin
            live_word = trace_id_pkg::ZERO_WORD;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   // only the hold control takes writes; every other word drops them
   always_comb begin
      st_d = st_q;
      if (!st_q.hold) begin
         st_d.perm = perm_live;
      end
      if (wr_in && (addr_in == trace_id_pkg::PERM_HOLD_OFF)) begin // R15
         st_d.hold = wdata_in[0];
      end
      // writes elsewhere leave all state alone
   end

   // state register
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q.perm <= trace_id_pkg::PERM_RESET;
         st_q.hold <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port with the identification table

   // the read data register lives in the read port
   id_read_port #(
      .PART_NUM (PART_NUM),
      .DESIGNER (DESIGNER),
      .CONTIN   (CONTIN),
      .REVISION (REVISION)
   ) u_read_port (
      .core_clk_in  (core_clk_in),
      .nrst_in      (nrst_in),
      .addr_in      (addr_in),
      .rd_in        (rd_in),
      .live_sel_in  (live_sel),
      .live_word_in (live_word),
      .rdata_out    (rdata_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!nrst_in);

   // read strobes at each offset
   logic rd_perm;   // read of permission status
   logic rd_arch;   // read of architecture word
   logic rd_cap;    // read of capability word
   logic rd_class;  // read of class word
   logic rd_pid4;   // read of id 4
   logic rd_pid0;   // read of id 0
   logic rd_pid1;   // read of id 1
   logic rd_pid2;   // read of id 2
   logic rd_idres;  // read of ids 5 to 7
   assign rd_perm  = rd_in && addr_in == trace_id_pkg::PERM_STATUS_OFF;
   assign rd_arch  = rd_in && addr_in == trace_id_pkg::ARCH_ID_OFF;
   assign rd_cap   = rd_in && addr_in == trace_id_pkg::DEV_CAP_OFF;
   assign rd_class = rd_in && addr_in == trace_id_pkg::DEV_CLASS_OFF;
   assign rd_pid4  = rd_in && addr_in == trace_id_pkg::PID4_OFF;
   assign rd_pid0  = rd_in && addr_in == trace_id_pkg::PID0_OFF;
   assign rd_pid1  = rd_in && addr_in == trace_id_pkg::PID1_OFF;
   assign rd_pid2  = rd_in && addr_in == trace_id_pkg::PID2_OFF;
   assign rd_idres = rd_in && (addr_in == trace_id_pkg::PID5_OFF ||
                               addr_in == trace_id_pkg::PID6_OFF ||
                               addr_in == trace_id_pkg::PID7_OFF);

   // an enabled field, tracked freely, reads enabled two cycles later
   chk_perm_enabled_read: assert property ( // R1
      (!st_q.hold && PERM_IMPL[0] && perm_enable_in[0]) ##1 rd_perm
      |=> rdata_out[1:0] == trace_id_pkg::PERM_ENABLED)
      else $error("enabled permission field misreported");

   // the reserved code never appears in the snapshot
   chk_perm_no_reserved: assert property ( // R1
      st_q.perm[1:0] != trace_id_pkg::PERM_RESERVED &&
      st_q.perm[3:2] != trace_id_pkg::PERM_RESERVED &&
      st_q.perm[5:4] != trace_id_pkg::PERM_RESERVED)
      else $error("reserved permission code reported");

   chk_arch_reads_zero: assert property ( // R2
      rd_arch |=> rdata_out == trace_id_pkg::ARCH_ID_VAL)
      else $error("architecture word not zero");

   chk_cap_word_value: assert property ( // R3
      rd_cap |=> rdata_out == trace_id_pkg::DEV_CAP_VAL)
      else $error("capability word wrong");

   chk_cap_fields: assert property ( // R4
      rd_cap |=> rdata_out[trace_id_pkg::CLOCK_REL_BIT] &&
                 rdata_out[4:0] == 5'h00 && // R5
                 rdata_out[8:6] == 3'h0 &&  // R6
                 rdata_out[11:9] == 3'h0 && // R7
                 !rdata_out[trace_id_pkg::CAPTURE_CTRL_BIT]) // R8
      else $error("capability field wrong");

   chk_class_value: assert property ( // R10
      rd_class |=> rdata_out == trace_id_pkg::DEV_CLASS_VAL)
      else $error("device class wrong");

   chk_id4_size_cont: assert property ( // R11
      rd_pid4 |=> rdata_out[7:4] == 4'h0 && rdata_out[3:0] == CONTIN)
      else $error("id 4 wrong");

   chk_id_upper_zero: assert property ( // R12
      (rd_pid4 || rd_pid0 || rd_pid1 || rd_pid2) |=>
         rdata_out[31:8] == 24'h000000)
      else $error("id upper bits not zero");

   chk_id_reserved: assert property ( // R12
      rd_idres |=> rdata_out == trace_id_pkg::ZERO_WORD)
      else $error("reserved id word not zero");

   chk_part_number: assert property ( // R13
      rd_pid0 ##1 rd_pid1 |-> rdata_out == {24'h000000, PART_NUM[7:0]}
         ##1 rdata_out[3:0] == PART_NUM[11:8])
      else $error("part number wrong");

   chk_designer_code: assert property ( // R14
      rd_pid2 |=> rdata_out[2:0] == DESIGNER[6:4] && rdata_out[3])
      else $error("designer code wrong");

   chk_write_ignored: assert property ( // R15
      (wr_in && addr_in == trace_id_pkg::DEV_CAP_OFF) ##2 rd_cap
      |=> rdata_out == trace_id_pkg::DEV_CAP_VAL)
      else $error("write changed capability word");

   // a held snapshot stays put whatever the enables do
   chk_hold_freezes: assert property ( // R1
      st_q.hold && !(wr_in && addr_in == trace_id_pkg::PERM_HOLD_OFF)
      |=> $stable(st_q.perm))
      else $error("held permission snapshot moved");

   // main scenarios
   cov_cap_read: cover property (rd_cap ##1 rd_class);
   cov_id_walk: cover property (rd_pid0 ##1 rd_pid1 ##1 rd_pid2);
   cov_hold_read: cover property (st_q.hold ##1 rd_perm);

endmodule

`default_nettype wire

/* shared/trace_id_pkg.sv */
// constants for the trace-port identification and capability registers
package trace_id_pkg;

   // register port geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // byte offsets of the mapped words
   localparam logic [11:0] PERM_HOLD_OFF   = 12'hF80;
   localparam logic [11:0] PERM_STATUS_OFF = 12'hFB8;
   localparam logic [11:0] ARCH_ID_OFF     = 12'hFBC;
   localparam logic [11:0] DEV_CAP_OFF     = 12'hFC8;
   localparam logic [11:0] DEV_CLASS_OFF   = 12'hFCC;
   localparam logic [11:0] PID4_OFF        = 12'hFD0;
   localparam logic [11:0] PID5_OFF        = 12'hFD4;
   localparam logic [11:0] PID6_OFF        = 12'hFD8;
   localparam logic [11:0] PID7_OFF        = 12'hFDC;
   localparam logic [11:0] PID0_OFF        = 12'hFE0;
   localparam logic [11:0] PID1_OFF        = 12'hFE4;
   localparam logic [11:0] PID2_OFF        = 12'hFE8;

   // debug-permission field layout: three two-bit fields
   localparam int PERM_FIELDS = 3;
   localparam int PERM_W      = 2;
   localparam int NS_INV_LSB    = 0;   // nonsecure_invasive_perm
   localparam int NS_NONINV_LSB = 2;   // nonsecure_noninvasive_perm
   localparam int SEC_INV_LSB   = 4;   // secure_invasive_perm

   // debug-permission field codes
   localparam logic [1:0] PERM_ABSENT   = 2'h0;
   localparam logic [1:0] PERM_RESERVED = 2'h1;
   localparam logic [1:0] PERM_DISABLED = 2'h2;
   localparam logic [1:0] PERM_ENABLED  = 2'h3;
   localparam logic [5:0] PERM_RESET    = 6'h00;

   // capability word fields
   localparam int MUX_KIND_LSB      = 0;
   localparam int MUX_KIND_MSB      = 4;
   localparam int CLOCK_REL_BIT     = 5;
   localparam int DEPTH_LSB         = 6;
   localparam int DEPTH_MSB         = 8;
   localparam int CLK_DATA_BIT      = 9;
   localparam int SER_MAN_BIT       = 10;
   localparam int SER_NRZ_BIT       = 11;
   localparam int CAPTURE_CTRL_BIT  = 16;
   localparam logic [4:0] MUX_KIND_VAL  = 5'h00;
   localparam logic       CLOCK_REL_VAL = 1'h1;
   localparam logic [2:0] DEPTH_VAL     = 3'h0;
   localparam logic       CLK_DATA_VAL  = 1'h0;
   localparam logic       SER_MAN_VAL   = 1'h0;
   localparam logic       SER_NRZ_VAL   = 1'h0;
   localparam logic       CAPTURE_VAL   = 1'h0;

   // fixed word values
   localparam logic [31:0] ARCH_ID_VAL   = 32'h00000000;
   localparam logic [31:0] DEV_CAP_VAL   = 32'h00000020;
   localparam logic [31:0] DEV_CLASS_VAL = 32'h00000011;
   localparam logic [31:0] ZERO_WORD     = 32'h00000000;

   // identification word layout
   localparam logic [3:0] ID_SIZE_VAL = 4'h0;  // unknown 4KB block count
   localparam logic       ID_JEDEC    = 1'h1;  // jedec-assigned code used
   localparam logic [23:0] ID_PAD     = 24'h000000;

endpackage

/* verilog/id_read_port.sv */
// read-data register and identification word table of the trace-port block
`timescale 1ns/1ns
`default_nettype none

module id_read_port #(
   parameter logic [11:0] PART_NUM = 12'h123, // arbitrary value
   parameter logic [6:0]  DESIGNER = 7'h25,   // arbitrary value
   parameter logic [3:0]  CONTIN   = 4'h3,    // arbitrary value
   parameter logic [3:0]  REVISION = 4'h2     // arbitrary value
) (
   input  wire logic        core_clk_in,  // block clock
   input  wire logic        nrst_in,      // async reset, active low
   input  wire logic [11:0] addr_in,      // byte address of the read
   input  wire logic        rd_in,        // read strobe
   input  wire logic        live_sel_in,  // word comes from live_word_in
   input  wire logic [31:0] live_word_in, // non-table word for this read
   output logic [31:0]      rdata_out     // read data, one cycle later
);

   // all state of this module
   typedef struct packed {
      logic [31:0] rdata;
   } port_state_t;

   port_state_t st_q;  // registered state
   port_state_t st_d;  // next state
   logic [31:0] tbl_word; // table word for addr_in

   ////////////////////////////////////////////////////////////////////////
   // identification table: upper 24 bits are always zero
   always_comb begin
      unique case (addr_in)
         trace_id_pkg::PID4_OFF:
            tbl_word = {trace_id_pkg::ID_PAD, trace_id_pkg::ID_SIZE_VAL,
                        CONTIN}; // R11 R14
         trace_id_pkg::PID0_OFF:
            tbl_word = {trace_id_pkg::ID_PAD, PART_NUM[7:0]}; // R13
         trace_id_pkg::PID1_OFF:
            tbl_word = {trace_id_pkg::ID_PAD, DESIGNER[3:0],
                        PART_NUM[11:8]}; // R13 R14
         trace_id_pkg::PID2_OFF:
            tbl_word = {trace_id_pkg::ID_PAD, REVISION,
                        trace_id_pkg::ID_JEDEC, DESIGNER[6:4]}; // R14
         // reserved id words and unmapped offsets read zero
         default: tbl_word = trace_id_pkg::ZERO_WORD; // R12
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // read data stand only in the cycle after the strobe
   always_comb begin
      st_d = st_q;
      if (!rd_in) begin
         st_d.rdata = trace_id_pkg::ZERO_WORD;
      end else if (live_sel_in) begin
         st_d.rdata = live_word_in;
      end else begin
         st_d.rdata = tbl_word;
      end
   end

   // state register
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata_out = st_q.rdata;

endmodule

`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the trace-port identification register bank
`timescale 1ns/1ns
`default_nettype none

module testbench;

   //////////////////////////////////////////////////////////////////////////
   // identity parameters handed to the bank; values are arbitrary
   localparam logic [2:0]  PERM_IMPL = 3'h5;   // middle field absent, code 0
   localparam logic [11:0] PART_NUM  = 12'h5A3; // arbitrary value
   localparam logic [6:0]  DESIGNER  = 7'h4C;   // arbitrary value
   localparam logic [3:0]  CONTIN    = 4'h6;    // arbitrary value
   localparam logic [3:0]  REVISION  = 4'h2;    // arbitrary value

   logic        core_clk_in;     // 10 MHz block clock
   logic        nrst_in;         // async reset, active low
   logic [11:0] addr_in;         // byte address
   logic [31:0] wdata_in;        // write data
   logic        wr_in;           // write strobe
   logic        rd_in;           // read strobe
   logic [2:0]  perm_enable_in;  // permission enables
   logic [31:0] rdata_out;       // read data
   logic [31:0] v;               // last word read
   logic [2:0]  en_old;          // enables frozen by the hold bit
   int          bad_count;       // mismatches
   int          tests_run;       // comparisons made
   logic [11:0] addrs [13];      // every word walked by the table loop
   logic [11:0] burst [5];       // order of the back-to-back reads

   trace_id_regs #(
      .PERM_IMPL (PERM_IMPL),
      .PART_NUM  (PART_NUM),
      .DESIGNER  (DESIGNER),
      .CONTIN    (CONTIN),
      .REVISION  (REVISION)
   ) u_dut (
      .core_clk_in    (core_clk_in),
      .nrst_in        (nrst_in),
      .addr_in        (addr_in),
      .wdata_in       (wdata_in),
      .wr_in          (wr_in),
      .rd_in          (rd_in),
      .perm_enable_in (perm_enable_in),
      .rdata_out      (rdata_out)
   );

   //////////////////////////////////////////////////////////////////////////
   // clock and watchdog; the run needs well under 2000 cycles
   initial begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   initial begin
      repeat (5000) @(posedge core_clk_in);
      bad_count++;
      give_verdict();
   end

   //////////////////////////////////////////////////////////////////////////
   // comparison and closing
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////////
   // bus cycles: one-cycle strobes, data sampled in the cycle after a read
   task automatic wr_word(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      wr_in    <= 1'b1;
      addr_in  <= a;
      wdata_in <= d;
      @(posedge core_clk_in);
      wr_in    <= 1'b0;
   endtask

   task automatic rd_word(input logic [11:0] a, output logic [31:0] d);
      @(posedge core_clk_in);
      rd_in   <= 1'b1;
      addr_in <= a;
      @(posedge core_clk_in);
      rd_in   <= 1'b0;
      #1 d = rdata_out;
   endtask

   //////////////////////////////////////////////////////////////////////////
   // expectations worked out from the register map
   function automatic logic [31:0] exp_perm(input logic [2:0] en);
      logic [31:0] w;
      w = 32'h00000000;
      for (int i = 0; i < 3; i++) begin
         if (PERM_IMPL[i]) begin
            w[2*i +: 2] = en[i] ? trace_id_pkg::PERM_ENABLED
                                : trace_id_pkg::PERM_DISABLED;
         end
      end
      return w;
   endfunction

   function automatic logic [31:0] exp_word(input logic [11:0] a);
      case (a)
         12'hFC8: return 32'h00000020;
         12'hFCC: return 32'h00000011;
         12'hFD0: return {24'h000000, 4'h0, CONTIN};
         12'hFE0: return {24'h000000, PART_NUM[7:0]};
         12'hFE4: return {24'h000000, DESIGNER[3:0], PART_NUM[11:8]};
         12'hFE8: return {24'h000000, REVISION, 1'b1, DESIGNER[6:4]};
         default: return 32'h00000000; // arch word, ids 5-7, unmapped
      endcase
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      nrst_in        = 1'b0;
      addr_in        = 12'h000;
      wdata_in       = 32'h00000000;
      wr_in          = 1'b0;
      rd_in          = 1'b0;
      perm_enable_in = 3'h0;
      bad_count      = 0;
      tests_run      = 0;
      addrs = '{12'hFBC, 12'hFC8, 12'hFCC, 12'hFD0, 12'hFD4, 12'hFD8,
                12'hFDC, 12'hFE0, 12'hFE4, 12'hFE8, 12'hFEC, 12'hFC9,
                12'h000};
      burst = '{12'hFC8, 12'hFCC, 12'hFE0, 12'hFE4, 12'hFE8};
      void'($urandom(27));
      repeat (8) @(posedge core_clk_in);
      nrst_in <= 1'b1;

      // every fixed-value word and three unmapped offsets, then random writes to it and a second read
      foreach (addrs[i]) begin
         rd_word(addrs[i], v);
         check("word", v, exp_word(addrs[i]));
         wr_word(addrs[i], $urandom());
         rd_word(addrs[i], v);
         check("after write", v, exp_word(addrs[i]));
      end

      // capability fields one by one
      rd_word(12'hFC8, v);
      check("clock relation", {31'h0, v[5]}, 32'h00000001);
      check("mux kind", {27'h0, v[4:0]}, 32'h00000000);
      check("depth", {29'h0, v[8:6]}, 32'h00000000);
      check("serial bits", {30'h0, v[11:10]}, 32'h00000000);
      check("capture bit", {31'h0, v[16]}, 32'h00000000);
      check("clk data bit", {31'h0, v[9]}, 32'h00000000);
      rd_word(12'hFD0, v);
      check("size field", {28'h0, v[7:4]}, 32'h00000000);
      #100 check("idle data", rdata_out, 32'h00000000);

      // back-to-back reads with no gap: capability, class, ids 0 to 2;
      // each word is looked at in the cycle after its strobe
      for (int i = 0; i <= 5; i++) begin
         @(posedge core_clk_in);
         rd_in   <= (i < 5);
         addr_in <= burst[i % 5];
         if (i > 0) begin
            #1 check("burst", rdata_out, exp_word(burst[i-1]));
         end
      end

      // every enable combination, then random ones
      for (int i = 0; i < 24; i++) begin
         @(posedge core_clk_in);
         perm_enable_in <= (i < 8) ? i[2:0] : 3'($urandom());
         repeat (2) @(posedge core_clk_in);
         rd_word(12'hFB8, v);
         check("perm status", v, exp_perm(perm_enable_in));
      end

      // hold bit freezes the permission snapshot
      en_old = perm_enable_in;
      wr_word(12'hF80, 32'hFFFFFFFF);
      rd_word(12'hF80, v);
      check("hold bit", v, 32'h00000001);
      perm_enable_in <= ~en_old;
      repeat (3) @(posedge core_clk_in);
      rd_word(12'hFB8, v);
      check("held status", v, exp_perm(en_old));
      wr_word(12'hF80, 32'h00000000);
      repeat (2) @(posedge core_clk_in);
      rd_word(12'hFB8, v);
      check("released status", v, exp_perm(~en_old));

      // second reset in mid-run, while read data stand, clears the hold bit
      wr_word(12'hF80, 32'h00000001);
      @(posedge core_clk_in);
      rd_in   <= 1'b1;
      addr_in <= 12'hFC8;
      @(posedge core_clk_in);
      rd_in   <= 1'b0;
      #1 check("cap before reset", rdata_out, 32'h00000020);
      nrst_in = 1'b0;
      #1 check("data in reset", rdata_out, 32'h00000000);
      repeat (3) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      rd_word(12'hF80, v);
      check("hold after reset", v, 32'h00000000);
      rd_word(12'hFC8, v);
      check("cap after reset", v, 32'h00000020);
      give_verdict();
   end

endmodule

`default_nettype wire
